// ### dtp_defs.svh
// dtp_defs.svh: offsets, field positions, reset values and codes of the
// task parameter and fault registers.
// assumes: included by bare name; definitions only.
`ifndef DTP_DEFS_SVH
`define DTP_DEFS_SVH

`define DTP_OFS_FAULT 10'h1F1
`define DTP_OFS_COUNT 10'h1F2
`define DTP_OFS_SECTOR 10'h1F3
`define DTP_OFS_TRK_LO 10'h1F4
`define DTP_OFS_TRK_HI 10'h1F5

`define DTP_BIT_BADBLK 7
`define DTP_BIT_ECC 6
`define DTP_BIT_HDRMISS 4
`define DTP_BIT_ABORT 2
`define DTP_BIT_TRK0 1
`define DTP_BIT_DAMMISS 0

`define DTP_RST_BYTE 8'h00
`define DTP_TRK_HI_MASK 8'h03
`define DTP_RESTORE_STEPS 11'h7FF

`define DTP_DIAG_OK 8'h01
`define DTP_DIAG_CORE 8'h02
`define DTP_DIAG_BUFRAM 8'h03
`define DTP_DIAG_REGACC 8'h04
`define DTP_DIAG_ROMRAM 8'h05

`endif

// ### dtp_pkg.sv
// dtp_pkg.sv: types shared by the task parameter register bank.
// assumes: compiled before the design modules.
package dtp_pkg;

    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } dtp_bus_s;

    typedef struct packed {
        logic badBlock;
        logic eccFail;
        logic headerMiss;
        logic driveFault;
        logic restoreStep;
        logic trackZero;
        logic dataMarkMiss;
        logic cmdInvalid;
        logic seekIncomplete;
    } dtp_evt_s;

    typedef enum logic [2:0] {
        DTP_IDLE = 3'b001,
        DTP_RUN = 3'b010,
        DTP_DIAG = 3'b100
    } dtp_state_e;

    typedef struct packed {
        logic [7:0] stepCnt;
        logic [7:0] rdata;
    } dtp_step_s;

endpackage

// ### dtp_step_reg.sv
`timescale 1ns/1ps
// dtp_step_reg.sv: one host-writable byte register that the device can step.
// assumes: write and step never asserted together by the parent.
module dtp_step_reg #(
    parameter bit UP = 1'b1
) (
    input wire logic mclk,
    input wire logic rstSync_n,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic step,
    output logic [7:0] value
);
    import dtp_pkg::*;
    `include "dtp_defs.svh"

    logic [7:0] value_r;
    logic [7:0] value_nxt;

    always_comb begin
        value_nxt = value_r;
        if (wrEn) begin
            value_nxt = wrData;
        end else if (step) begin
            value_nxt = UP ? value_r + 8'h01 : value_r - 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            value_r <= `DTP_RST_BYTE;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign value = value_r;
endmodule // dtp_step_reg

// ### dtp_task_regs.sv
`timescale 1ns/1ps
// dtp_task_regs.sv: fault cause, sector count, sector number and track
// address registers of the disk controller, on the 8-bit I/O port path.
// assumes: I/O strobes synchronous to mclk, one cycle per access; event
// inputs are one-cycle pulses from the sequencing and stepping logic.
//
// Functional notes
// - bad block marking in a sector header sets fault bit 7.
// - uncorrectable ECC syndrome sets fault bit 6.
// - header not matched in eight revolutions or header CRC sets bit 4.
// - command issued while drive not ready or write fault sets bit 2.
// - 2047 restore steps without track zero sets fault bit 1.
// - header found but no data address mark sets fault bit 0.
// - power-up and diagnose load a self-test result code.
// - result codes 01H ok, 02H core, 03H RAM, 04H register, 05H ROM.
// - sector count decrements after each sector done.
// - sector number increments after each sector done.
// - track low holds cylinder bits 7-0, host read and write.
// - track high holds cylinder bits 9-8; bits 7-2 read zero.
// - any command error, invalid code or no seek complete, aborts.
module dtp_task_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input dtp_pkg::dtp_bus_s ioBus,
    output logic [7:0] ioRdata,
    output logic ioRdValid,
    input wire logic cmdAccept,
    input wire logic cmdIsRestore,
    input wire logic cmdIsDiag,
    input wire logic driveReady,
    input wire logic writeFault,
    input dtp_pkg::dtp_evt_s evt,
    input wire logic sectorDone,
    input wire logic diagDone,
    input wire logic [7:0] diagCode,
    output logic cmdAbort,
    output logic faultAny,
    output logic diagBusy,
    output logic [9:0] trackAddr,
    output logic [7:0] firstSector,
    output logic [7:0] sectorsLeft
);
    import dtp_pkg::*;
    `include "dtp_defs.svh"

    typedef struct packed {
        dtp_state_e state;
        logic [7:0] fault;
        logic [7:0] trkLo;
        logic [1:0] trkHi;
        logic [10:0] steps;
        logic [7:0] rdata;
        logic rdValid;
        logic abort;
    } dtp_core_s;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rstMeta_r;
    logic rstSync_n;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_n <= rstMeta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic wrStb;
    logic rdStb;
    logic wrCount;
    logic wrSector;
    logic [7:0] countVal;
    logic [7:0] sectorVal;
    logic running;
    logic stepOk;
    assign wrStb = ioBus.cs & ioBus.wr;
    assign rdStb = ioBus.cs & ioBus.rd;
    assign wrCount = wrStb && ioBus.addr == `DTP_OFS_COUNT;
    assign wrSector = wrStb && ioBus.addr == `DTP_OFS_SECTOR;

    dtp_core_s core_r;
    dtp_core_s core_nxt;
    assign running = core_r.state == DTP_RUN;
    assign stepOk = running & sectorDone & ~wrCount & ~wrSector;

    // sector count steps down, sector number up, per finished sector
    dtp_step_reg #(.UP(1'b0)) uCount (
        .mclk(mclk),
        .rstSync_n(rstSync_n),
        .wrEn(wrCount),
        .wrData(ioBus.wdata),
        .step(stepOk),
        .value(countVal)
    );

    dtp_step_reg #(.UP(1'b1)) uSector (
        .mclk(mclk),
        .rstSync_n(rstSync_n),
        .wrEn(wrSector),
        .wrData(ioBus.wdata),
        .step(stepOk),
        .value(sectorVal)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic [7:0] setBits;
    logic abortNow;
    always_comb begin
        core_nxt = core_r;
        core_nxt.rdValid = 1'b0;
        core_nxt.abort = 1'b0;
        setBits = 8'h00;
        abortNow = 1'b0;
        case (core_r.state)
            DTP_IDLE: begin
                if (cmdAccept) begin
                    core_nxt.fault = 8'h00;
                    core_nxt.steps = 11'h000;
                    abortNow = ~driveReady | writeFault | evt.cmdInvalid
                        | evt.seekIncomplete;
                    if (abortNow) begin
                        core_nxt.fault[`DTP_BIT_ABORT] = 1'b1;
                        core_nxt.abort = 1'b1;
                    end else if (cmdIsDiag) begin
                        core_nxt.state = DTP_DIAG;
                    end else begin
                        core_nxt.state = DTP_RUN;
                    end
                end
            end
            DTP_RUN: begin
                setBits[`DTP_BIT_BADBLK] = evt.badBlock;
                setBits[`DTP_BIT_ECC] = evt.eccFail;
                setBits[`DTP_BIT_HDRMISS] = evt.headerMiss;
                setBits[`DTP_BIT_DAMMISS] = evt.dataMarkMiss;
                if (~driveReady | writeFault | evt.driveFault) begin
                    setBits[`DTP_BIT_ABORT] = 1'b1;
                end
                if (cmdIsRestore && evt.restoreStep
                    && core_r.steps != `DTP_RESTORE_STEPS) begin
                    core_nxt.steps = core_r.steps + 11'h001;
                end
                if (cmdIsRestore && !evt.trackZero
                    && core_r.steps == `DTP_RESTORE_STEPS) begin
                    setBits[`DTP_BIT_TRK0] = 1'b1;
                end
                core_nxt.fault = core_r.fault | setBits;
                if (setBits[`DTP_BIT_ABORT] || setBits[`DTP_BIT_TRK0]) begin
                    core_nxt.abort = 1'b1;
                    core_nxt.state = DTP_IDLE;
                end else if (cmdIsRestore && evt.trackZero) begin
                    core_nxt.state = DTP_IDLE;
                end else if (!cmdIsRestore && stepOk
                    && countVal == 8'h01) begin
                    core_nxt.state = DTP_IDLE;
                end
            end
            DTP_DIAG: begin
                if (diagDone) begin
                    core_nxt.fault = diagCode;
                    core_nxt.state = DTP_IDLE;
                end
            end
            default: begin
                core_nxt.state = DTP_IDLE;
            end
        endcase
        if (wrStb && ioBus.addr == `DTP_OFS_TRK_LO) begin
            core_nxt.trkLo = ioBus.wdata;
        end
        if (wrStb && ioBus.addr == `DTP_OFS_TRK_HI) begin
            core_nxt.trkHi = ioBus.wdata[1:0];
        end
        if (rdStb) begin
            core_nxt.rdValid = 1'b1;
            case (ioBus.addr)
                `DTP_OFS_FAULT: core_nxt.rdata = core_r.fault;
                `DTP_OFS_COUNT: core_nxt.rdata = countVal;
                `DTP_OFS_SECTOR: core_nxt.rdata = sectorVal;
                `DTP_OFS_TRK_LO: core_nxt.rdata = core_r.trkLo;
                `DTP_OFS_TRK_HI: core_nxt.rdata = {6'h00, core_r.trkHi};
                default: core_nxt.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; power-up runs the self-test state first
    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            core_r.state <= DTP_DIAG;
            core_r.fault <= `DTP_RST_BYTE;
            core_r.trkLo <= `DTP_RST_BYTE;
            core_r.trkHi <= 2'h0;
            core_r.steps <= 11'h000;
            core_r.rdata <= `DTP_RST_BYTE;
            core_r.rdValid <= 1'b0;
            core_r.abort <= 1'b0;
        end else begin
            core_r <= core_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign ioRdata = core_r.rdata;
    assign ioRdValid = core_r.rdValid;
    assign cmdAbort = core_r.abort;
    assign faultAny = core_r.fault != 8'h00 && core_r.state != DTP_DIAG;
    assign diagBusy = core_r.state == DTP_DIAG;
    assign trackAddr = {core_r.trkHi, core_r.trkLo};
    assign firstSector = sectorVal;
    assign sectorsLeft = countVal;
endmodule // dtp_task_regs

// ### dtp_task_regs_sva.sv
// dtp_task_regs_sva.sv: port-level checks of the task register bank.
// assumes: bound to dtp_task_regs, single mclk domain.
`timescale 1ns/1ps
`include "dtp_defs.svh"
module dtp_task_regs_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input dtp_pkg::dtp_bus_s ioBus,
    input wire logic ioRdValid,
    input wire logic cmdAccept,
    input wire logic cmdIsDiag,
    input wire logic driveReady,
    input wire logic writeFault,
    input dtp_pkg::dtp_evt_s evt,
    input wire logic sectorDone,
    input wire logic diagDone,
    input wire logic cmdAbort,
    input wire logic faultAny,
    input wire logic diagBusy,
    input wire logic [9:0] trackAddr,
    input wire logic [7:0] firstSector,
    input wire logic [7:0] sectorsLeft
);
    import dtp_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic rd;
    logic wr;
    logic go;
    assign rd = ioBus.cs && ioBus.rd;
    assign wr = ioBus.cs && ioBus.wr;
    assign go = cmdAccept && !diagBusy && !cmdIsDiag;
    a_read_answer: assert property (rd |=> ioRdValid)
        else $error("read strobe not answered");
    a_abort_drive: assert property
        (go && (!driveReady || writeFault) |=> cmdAbort)
        else $error("drive state abort missing");
    a_abort_error: assert property
        (go && (evt.cmdInvalid || evt.seekIncomplete) |=> cmdAbort)
        else $error("command error abort missing");
    a_clear_flags: assert property
        (go && driveReady && !writeFault && evt == '0 |=> !faultAny)
        else $error("fault flags not cleared");
    a_count_step: assert property (sectorDone && !wr |=>
        sectorsLeft == $past(sectorsLeft) - 8'h01)
        else $error("sector count not decremented");
    a_sector_step: assert property (sectorDone && !wr |=>
        firstSector == $past(firstSector) + 8'h01)
        else $error("sector number not incremented");
    a_track_low: assert property
        (wr && ioBus.addr == `DTP_OFS_TRK_LO
        |=> trackAddr[7:0] == $past(ioBus.wdata))
        else $error("track low byte not written");
    a_track_high: assert property
        (wr && ioBus.addr == `DTP_OFS_TRK_HI
        |=> trackAddr[9:8] == $past(ioBus.wdata[1:0]))
        else $error("track high bits not written");
    a_diag_end: assert property (diagBusy && diagDone |=> !diagBusy)
        else $error("self-test did not end");
    cover property (sectorDone ##1 sectorDone);
    cover property (go ##1 cmdAbort);
    cover property (diagBusy && diagDone);
endmodule // dtp_task_regs_sva

bind dtp_task_regs dtp_task_regs_sva i_dtp_task_regs_sva (
    .mclk(mclk), .rst_n(rst_n), .ioBus(ioBus), .ioRdValid(ioRdValid),
    .cmdAccept(cmdAccept), .cmdIsDiag(cmdIsDiag), .driveReady(driveReady),
    .writeFault(writeFault), .evt(evt), .sectorDone(sectorDone),
    .diagDone(diagDone), .cmdAbort(cmdAbort), .faultAny(faultAny),
    .diagBusy(diagBusy), .trackAddr(trackAddr),
    .firstSector(firstSector), .sectorsLeft(sectorsLeft)
);

// ### dtp_host_model.sv
// dtp_host_model.sv: host processor on the 8-bit I/O port path.
// assumes: bench calls io_write and io_read right after a rising edge.
`timescale 1ns/1ps
module dtp_host_model (
    input wire logic mclk,
    output dtp_pkg::dtp_bus_s ioBus,
    input wire logic [7:0] ioRdata,
    input wire logic ioRdValid
);
    import dtp_pkg::*;
    initial ioBus = '0;
    // released address and data are inverted so stale values never match
    task automatic access(input logic w, input logic [9:0] a,
                          input logic [7:0] d);
        @(posedge mclk);
        ioBus <= '{cs: 1'b1, rd: !w, wr: w, addr: a, wdata: d};
        @(posedge mclk);
        ioBus <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic io_write(input logic [9:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask
    // read waits up to three cycles for ioRdValid; d stays x if none comes
    task automatic io_read(input logic [9:0] a, output logic [7:0] d);
        d = 'x;
        access(1'b0, a, ~a[7:0]);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            if (ioRdValid === 1'b1) begin
                d = ioRdata;
                break;
            end
        end
    endtask
endmodule // dtp_host_model

// ### dtp_task_regs_test.sv
// dtp_task_regs_test.sv: self-checking bench of the task register bank.
// assumes: host model and checker compiled first.
`timescale 1ns/1ps
`include "dtp_defs.svh"
module dtp_task_regs_test;
    import dtp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    dtp_bus_s ioBus;
    logic [7:0] ioRdata, firstSector, sectorsLeft, rdv, s, n;
    logic [7:0] diagCode = 8'h00;
    logic ioRdValid, cmdAbort, faultAny, diagBusy;
    logic cmdAccept = 1'b0, cmdIsRestore = 1'b0, cmdIsDiag = 1'b0;
    logic driveReady = 1'b1, writeFault = 1'b0;
    logic sectorDone = 1'b0, diagDone = 1'b0;
    logic [9:0] trackAddr;
    dtp_evt_s evt = '0;
    logic [8:0] evMask [5] = '{9'h100, 9'h080, 9'h040, 9'h004, 9'h020};
    logic [7:0] evFault [5] = '{8'h80, 8'h40, 8'h10, 8'h01, 8'h04};
    int num_errors = 0, compares = 0, cycles = 0;
    always #5 mclk = ~mclk;
    dtp_host_model i_dtp_host_model (.mclk(mclk), .ioBus(ioBus),
        .ioRdata(ioRdata), .ioRdValid(ioRdValid));
    dtp_task_regs i_dtp_task_regs (.mclk(mclk), .rst_n(rst_n),
        .ioBus(ioBus), .ioRdata(ioRdata), .ioRdValid(ioRdValid),
        .cmdAccept(cmdAccept), .cmdIsRestore(cmdIsRestore),
        .cmdIsDiag(cmdIsDiag), .driveReady(driveReady),
        .writeFault(writeFault), .evt(evt), .sectorDone(sectorDone),
        .diagDone(diagDone), .diagCode(diagCode), .cmdAbort(cmdAbort),
        .faultAny(faultAny), .diagBusy(diagBusy), .trackAddr(trackAddr),
        .firstSector(firstSector), .sectorsLeft(sectorsLeft));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
        i_dtp_host_model.io_read(a, rdv);
        chk(16'(rdv), 16'(exp));
    endtask
    task automatic cmd(input logic rs, input logic dg);
        cmdIsRestore <= rs;
        cmdIsDiag <= dg;
        cmdAccept <= 1'b1;
        @(posedge mclk);
        cmdAccept <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pulse(input logic [8:0] v);
        evt <= dtp_evt_s'(v);
        @(posedge mclk);
        evt <= '0;
        @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            stop_test();
        end
    end
    initial begin
        void'($urandom(91));
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(16'(diagBusy), 16'h0001);
        for (int c = 1; c <= 5; c++) begin
            if (c > 1) cmd(1'b0, 1'b1);
            diagCode <= 8'(c);
            diagDone <= 1'b1;
            @(posedge mclk);
            diagDone <= 1'b0;
            @(posedge mclk);
            rdchk(`DTP_OFS_FAULT, 8'(c));
        end
        repeat (6) begin
            s = 8'($urandom);
            n = 8'($urandom);
            i_dtp_host_model.io_write(`DTP_OFS_TRK_LO, s);
            i_dtp_host_model.io_write(`DTP_OFS_TRK_HI, n);
            i_dtp_host_model.io_write(`DTP_OFS_FAULT, n);
            rdchk(`DTP_OFS_TRK_HI, n & `DTP_TRK_HI_MASK);
            rdchk(`DTP_OFS_TRK_LO, s);
            chk(16'(trackAddr), {6'h00, n[1:0], s});
            rdchk(`DTP_OFS_FAULT, `DTP_DIAG_ROMRAM);
        end
        rdchk(10'h1F0, 8'h00);
        for (int k = 0; k < 4; k++) begin
            driveReady <= (k != 0);
            writeFault <= (k == 1);
            evt <= dtp_evt_s'({7'h00, k == 2, k == 3});
            cmd(1'b0, 1'b0);
            driveReady <= 1'b1;
            writeFault <= 1'b0;
            evt <= '0;
            rdchk(`DTP_OFS_FAULT, 8'h04);
        end
        for (int k = 0; k < 5; k++) begin
            // a one-sector command, so that a finished sector ends it
            i_dtp_host_model.io_write(`DTP_OFS_COUNT, 8'h01);
            cmd(1'b0, 1'b0);
            pulse(evMask[k]);
            if (k < 4) begin
                sectorDone <= 1'b1;
                @(posedge mclk);
                sectorDone <= 1'b0;
                @(posedge mclk);
            end
            rdchk(`DTP_OFS_FAULT, evFault[k]);
        end
        for (int k = 0; k < 2; k++) begin
            cmd(1'b1, 1'b0);
            repeat (`DTP_RESTORE_STEPS - k) pulse(9'h010);
            evt <= dtp_evt_s'({5'h00, k == 1, 3'h0});
            repeat (2) @(posedge mclk);
            evt <= '0;
            rdchk(`DTP_OFS_FAULT, k == 0 ? 8'h02 : 8'h00);
        end
        repeat (3) begin
            s = 8'($urandom);
            n = 8'($urandom_range(8, 2));
            i_dtp_host_model.io_write(`DTP_OFS_COUNT, n);
            i_dtp_host_model.io_write(`DTP_OFS_SECTOR, s);
            cmd(1'b0, 1'b0);
            sectorDone <= 1'b1;
            repeat (n) @(posedge mclk);
            sectorDone <= 1'b0;
            @(posedge mclk);
            chk(16'(sectorsLeft), 16'h0000);
            chk(16'(firstSector), 16'(8'(s + n)));
            rdchk(`DTP_OFS_SECTOR, 8'(s + n));
        end
        stop_test();
    end
endmodule // dtp_task_regs_test
